// ==== hdl/ecg_pkg.sv ====
// Purpose: Shared codes, widths and carrier types for the event channel generator mux
// Assumes: One peripheral clock; generator inputs are levels or one-cycle strobes
// Notes: Codes are the 8-bit channel selection values
package ecg_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int ECG_SEL_W = 8;
  localparam int ECG_NUM_CHANNELS = 10;
  localparam int ECG_NUM_SERIAL = 6;
  localparam int ECG_NUM_SPI = 2;
  localparam int ECG_NUM_TYPE_B = 5;
  localparam int ECG_PORT_PINS = 8;

  // ----------------------------------------------------------------
  // Selection codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ECG_CODE_OFF = 8'h00;
  localparam logic [7:0] ECG_CODE_PIN_LO = 8'h40;
  localparam logic [7:0] ECG_CODE_PIN_HI = 8'h48;
  localparam logic [7:0] ECG_CODE_SERIAL = 8'h60;
  localparam logic [7:0] ECG_CODE_SPI = 8'h68;
  localparam logic [7:0] ECG_CODE_TA0 = 8'h80;
  localparam logic [7:0] ECG_CODE_TA1 = 8'h88;
  localparam logic [7:0] ECG_CODE_TB = 8'hA0;
  localparam logic [7:0] ECG_CODE_DT = 8'hB0;

  // Field offsets inside a type-A timer code group
  localparam logic [2:0] ECG_TA_OVERFLOW_OR_LOW_UNDERFLOW = 3'h0;
  localparam logic [2:0] ECG_TA_HIGH_BYTE_UNDERFLOW = 3'h1;
  localparam logic [2:0] ECG_TA_CMP0 = 3'h4;
  localparam logic [2:0] ECG_TA_CMP1 = 3'h5;
  localparam logic [2:0] ECG_TA_CMP2 = 3'h6;

  // Channel selection reset value
  localparam logic [7:0] ECG_SEL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic overflow_or_low_underflow;
    logic high_byte_underflow;
    logic compare0_match;
    logic compare1_match;
    logic compare2_match;
  } ecg_type_a_t;

  typedef struct packed {
    logic capture_flag_event;
    logic counter_overflow_event;
  } ecg_type_b_t;

  typedef struct packed {
    logic match_b_clear;
    logic match_a_set;
    logic match_b_set;
    logic programmable_event_out;
  } ecg_dead_time_t;

  // Synchronous generators, sampled on the peripheral clock
  typedef struct packed {
    logic [5:0] serial_host_clock;
    logic [1:0] spi_host_clock;
    ecg_type_a_t type_a_timer_zero;
    ecg_type_a_t type_a_timer_one;
    ecg_type_b_t [4:0] type_b_timer;
  } ecg_sync_gen_t;

  // Asynchronous generators: pin levels and dead-time timer events
  typedef struct packed {
    logic [7:0] io_port_a;
    logic [7:0] io_port_b;
    logic [7:0] io_port_c;
    logic [7:0] io_port_d;
    logic [7:0] io_port_e;
    logic [7:0] io_port_f;
    logic [7:0] io_port_g;
    ecg_dead_time_t dead_time_timer;
  } ecg_async_gen_t;

  // Input driver enables of every pin, one byte a port, ports a to g
  typedef logic [6:0][7:0] ecg_pin_enable_t;

endpackage : ecg_pkg

// ==== hdl/ecg_channel_sel.sv ====
// Purpose: One event channel: decodes its selection code into one generator
// Assumes: Sync inputs are already registered by the caller's clock domain
// Notes: Pin ports depend on the channel pair index
`timescale 1ns/10ps
module ecg_channel_sel
  import ecg_pkg::*;
#(
  parameter int CHANNEL = 0
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] sel,
  input wire ecg_sync_gen_t sync_gen,
  input wire ecg_async_gen_t async_gen,
  input wire ecg_pin_enable_t pin_enable,
  output logic event_out,
  output logic is_async
);

  // ----------------------------------------------------------------
  // Pin levels gated by their input driver
  // ----------------------------------------------------------------
  wire logic [7:0] port_a_lvl = async_gen.io_port_a & pin_enable[0];
  wire logic [7:0] port_b_lvl = async_gen.io_port_b & pin_enable[1];
  wire logic [7:0] port_c_lvl = async_gen.io_port_c & pin_enable[2];
  wire logic [7:0] port_d_lvl = async_gen.io_port_d & pin_enable[3];
  wire logic [7:0] port_e_lvl = async_gen.io_port_e & pin_enable[4];
  wire logic [7:0] port_f_lvl = async_gen.io_port_f & pin_enable[5];
  wire logic [7:0] port_g_lvl = async_gen.io_port_g & pin_enable[6];

  // Pair index picks which ports the pin codes reach
  localparam int PAIR = CHANNEL / 2;
  // Pairs four and up own no port on the lower pin codes, pairs three and up none on the upper
  localparam bit HAS_PIN_LO = (PAIR < 4);
  localparam bit HAS_PIN_HI = (PAIR < 3);
  wire logic [7:0] pin_lo_port = (PAIR == 0) ? port_a_lvl :
                                 (PAIR == 1) ? port_c_lvl :
                                 (PAIR == 2) ? port_e_lvl :
                                 (PAIR == 3) ? port_g_lvl : 8'h00;
  wire logic [7:0] pin_hi_port = (PAIR == 0) ? port_b_lvl :
                                 (PAIR == 1) ? port_d_lvl :
                                 (PAIR == 2) ? port_f_lvl : 8'h00;

  // ----------------------------------------------------------------
  // Type-A timer event picked by the low three code bits
  // ----------------------------------------------------------------
  function automatic logic ta_pick(input ecg_type_a_t t, input logic [2:0] f);
    case (f)
      ECG_TA_OVERFLOW_OR_LOW_UNDERFLOW: ta_pick = t.overflow_or_low_underflow;
      ECG_TA_HIGH_BYTE_UNDERFLOW: ta_pick = t.high_byte_underflow;
      ECG_TA_CMP0: ta_pick = t.compare0_match;
      ECG_TA_CMP1: ta_pick = t.compare1_match;
      ECG_TA_CMP2: ta_pick = t.compare2_match;
      default: ta_pick = 1'b0;
    endcase
  endfunction : ta_pick

  wire logic [4:0] hi5 = sel[7:3];
  wire logic [2:0] lo3 = sel[2:0];
  wire logic [3:0] tb_idx = sel[4:1];
  wire logic [7:0] dt_vec = {4'h0, async_gen.dead_time_timer};

  logic sync_sel;
  logic async_sel;
  logic async_hit;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    sync_sel = 1'b0;
    async_sel = 1'b0;
    async_hit = 1'b0;
    if (sel == ECG_CODE_OFF) begin
      sync_sel = 1'b0;
    end else if (hi5 == ECG_CODE_PIN_LO[7:3]) begin
      if (HAS_PIN_LO) begin
        async_sel = pin_lo_port[lo3];
        async_hit = 1'b1;
      end
    end else if (hi5 == ECG_CODE_PIN_HI[7:3]) begin
      if (HAS_PIN_HI) begin
        async_sel = pin_hi_port[lo3];
        async_hit = 1'b1;
      end
    end else if (hi5 == ECG_CODE_SERIAL[7:3]) begin
      if (lo3 < 3'(ECG_NUM_SERIAL)) begin
        sync_sel = sync_gen.serial_host_clock[lo3];
      end
    end else if (hi5 == ECG_CODE_SPI[7:3]) begin
      if (lo3 < 3'(ECG_NUM_SPI)) begin
        sync_sel = sync_gen.spi_host_clock[lo3[0]];
      end
    end else if (hi5 == ECG_CODE_TA0[7:3]) begin
      sync_sel = ta_pick(sync_gen.type_a_timer_zero, lo3);
    end else if (hi5 == ECG_CODE_TA1[7:3]) begin
      sync_sel = ta_pick(sync_gen.type_a_timer_one, lo3);
    end else if (sel[7:4] == ECG_CODE_TB[7:4]) begin
      if (tb_idx < 4'(ECG_NUM_TYPE_B)) begin
        sync_sel = sel[0] ? sync_gen.type_b_timer[tb_idx].counter_overflow_event
                          : sync_gen.type_b_timer[tb_idx].capture_flag_event;
      end
    end else if (hi5 == ECG_CODE_DT[7:3]) begin
      if (lo3 < 3'h4) begin
        async_sel = dt_vec[3'h3 - lo3];
        async_hit = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output: async passes straight, sync is registered once
  // ----------------------------------------------------------------
  logic sync_q;
  logic sync_d;
  assign sync_d = sync_sel;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign is_async = async_hit;
  assign event_out = async_hit ? async_sel : sync_q;

endmodule : ecg_channel_sel

// ==== hdl/ecg_event_channel_generator_mux.sv ====
// Purpose: Generator selection multiplexer for all event channels
// Assumes: Selection codes come from outside; no register bus
// Notes: Sync sources reach users one clock after the generator strobe
`timescale 1ns/10ps
module ecg_event_channel_generator_mux
  import ecg_pkg::*;
#(
  parameter int NUM_CHANNELS = ECG_NUM_CHANNELS
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [NUM_CHANNELS-1:0][7:0] channel_select,
  input wire ecg_sync_gen_t sync_gen,
  input wire ecg_async_gen_t async_gen,
  input wire ecg_pin_enable_t pin_enable,
  output logic [NUM_CHANNELS-1:0] event_channel,
  output logic [NUM_CHANNELS-1:0] channel_is_async
);

  // ----------------------------------------------------------------
  // One selector per channel
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_channel
    ecg_channel_sel #(
      .CHANNEL(ch)
    ) u_sel (
      .clock(clock),
      .reset_n(reset_n),
      .sel(channel_select[ch]),
      .sync_gen(sync_gen),
      .async_gen(async_gen),
      .pin_enable(pin_enable),
      .event_out(event_channel[ch]),
      .is_async(channel_is_async[ch])
    );
  end

endmodule : ecg_event_channel_generator_mux

// ==== test/ecg_mux_checker.sv ====
// Purpose: Port-level assertions for the event channel generator mux
// Assumes: Single clock domain, synchronous active-low reset
// Notes: Sync checks hold the code for two edges so the flop path is settled
`timescale 1ns/10ps
module ecg_mux_checker
  import ecg_pkg::*;
#(
  parameter int NUM_CHANNELS = ECG_NUM_CHANNELS
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [NUM_CHANNELS-1:0][7:0] channel_select,
  input wire ecg_sync_gen_t sync_gen,
  input wire ecg_async_gen_t async_gen,
  input wire ecg_pin_enable_t pin_enable,
  input wire logic [NUM_CHANNELS-1:0] event_channel,
  input wire logic [NUM_CHANNELS-1:0] channel_is_async
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire logic [7:0] s0 = channel_select[0];
  AST_CODE_OFF: assert property (channel_select[3] == 8'h00 ##1 channel_select[3] == 8'h00
    |-> !event_channel[3] && !channel_is_async[3])
    else $error("channel not idle with code zero");
  AST_SERIAL_CLK: assert property (s0 == 8'h65 ##1 s0 == 8'h65 |-> event_channel[0] == $past(sync_gen.serial_host_clock[5]))
    else $error("serial clock five not routed one cycle later");
  AST_SPI_CLK: assert property (s0 == 8'h68 ##1 s0 == 8'h68 |-> event_channel[0] == $past(sync_gen.spi_host_clock[0]))
    else $error("spi clock zero not routed");
  AST_TA_OVF: assert property (s0 == 8'h88 ##1 s0 == 8'h88
    |-> event_channel[0] == $past(sync_gen.type_a_timer_one.overflow_or_low_underflow))
    else $error("timer one overflow not routed");
  AST_TA_HIGH_BYTE_UNDERFLOW: assert property (s0 == 8'h81 ##1 s0 == 8'h81
    |-> event_channel[0] == $past(sync_gen.type_a_timer_zero.high_byte_underflow))
    else $error("timer zero high underflow not routed");
  AST_TA_CMP: assert property (s0 == 8'h8E ##1 s0 == 8'h8E
    |-> event_channel[0] == $past(sync_gen.type_a_timer_one.compare2_match))
    else $error("timer one compare two not routed");
  AST_TB_CAPTURE_FLAG_EVENT: assert property (s0 == 8'hA8 ##1 s0 == 8'hA8
    |-> event_channel[0] == $past(sync_gen.type_b_timer[4].capture_flag_event))
    else $error("type b timer four capture not routed");
  AST_PIN_B: assert property (channel_select[1] == 8'h4F
    |-> channel_is_async[1] && event_channel[1] == (async_gen.io_port_b[7] && pin_enable[1][7]))
    else $error("port b pin seven level wrong");
  AST_PIN_D: assert property (channel_select[3] == 8'h48
    |-> event_channel[3] == (async_gen.io_port_d[0] && pin_enable[3][0]))
    else $error("port d pin zero level wrong");
  AST_PIN_G_HI: assert property (channel_select[7][7:3] == 5'h09 ##1 channel_select[7][7:3] == 5'h09
    |-> !event_channel[7] && !channel_is_async[7])
    else $error("upper pin code not refused on channel seven");
  AST_DEAD_TIME: assert property (channel_select[9] == 8'hB3
    |-> channel_is_async[9] && event_channel[9] == async_gen.dead_time_timer.programmable_event_out)
    else $error("dead time event output not routed");
  cover property (s0 == 8'h80 ##1 event_channel[0]);
  cover property (channel_select[1] == 8'h40 && event_channel[1]);
  cover property (channel_select[9] == 8'hB0 && event_channel[9]);
endmodule : ecg_mux_checker

bind ecg_event_channel_generator_mux ecg_mux_checker #(.NUM_CHANNELS(NUM_CHANNELS)) ecg_mux_checker_i (
  .clock, .reset_n, .channel_select, .sync_gen, .async_gen, .pin_enable, .event_channel, .channel_is_async);

// ==== test/ecg_gen_model.sv ====
// Purpose: Peripheral generators and pin levels facing the mux
// Assumes: Random words come from the bench and change at the falling edge
// Notes: Enables are biased high so pin levels show often
`timescale 1ns/10ps
module ecg_gen_model
  import ecg_pkg::*;
(
  input wire logic clock,
  input wire logic [63:0] rnd_a,
  input wire logic [63:0] rnd_b,
  input wire logic [63:0] rnd_c,
  output ecg_sync_gen_t sync_gen,
  output ecg_async_gen_t async_gen,
  output ecg_pin_enable_t pin_enable
);
  initial begin
    sync_gen = '0;
    async_gen = '0;
    pin_enable = '0;
  end
  always @(negedge clock) begin
    sync_gen <= rnd_a[27:0];
    async_gen <= rnd_b[59:0];
    pin_enable <= rnd_c[55:0] | rnd_a[63:8];
  end
endmodule : ecg_gen_model

// ==== test/ecg_event_channel_generator_mux_tb.sv ====
// Purpose: Self-checking bench for the event channel generator mux
// Assumes: Inputs change at the falling edge; outputs compared before that change
// Notes: Sweeps every code on every channel, then random codes with a mid-run reset
`timescale 1ns/10ps
module ecg_event_channel_generator_mux_tb;
  import ecg_pkg::*;
  localparam int N = ECG_NUM_CHANNELS;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [N-1:0][7:0] channel_select = '0;
  logic [63:0] rnd_a = '0, rnd_b = '0, rnd_c = '0, seed = 64'h3F;
  logic [3:0] hi_tbl [6] = '{4'h0, 4'h4, 4'h6, 4'h8, 4'hA, 4'hB};
  ecg_sync_gen_t sync_gen;
  ecg_async_gen_t async_gen;
  ecg_pin_enable_t pin_enable;
  logic [N-1:0] event_channel, channel_is_async, exp_q = '0;
  int miscompares = 0, num_checks = 0;
  always #4 clock = ~clock;
  ecg_gen_model ecg_gen_model_i (.clock, .rnd_a, .rnd_b, .rnd_c, .sync_gen, .async_gen, .pin_enable);
  ecg_event_channel_generator_mux #(.NUM_CHANNELS(N)) ecg_event_channel_generator_mux_i (
    .clock, .reset_n, .channel_select, .sync_gen, .async_gen, .pin_enable, .event_channel, .channel_is_async);
  function automatic logic [63:0] xorshift(logic [63:0] x);
    x ^= x << 13;
    x ^= x >> 7;
    x ^= x << 17;
    return x;
  endfunction : xorshift
  // Returns {selects async source, its value}
  function automatic logic [1:0] ref_async(int ch, logic [7:0] c);
    logic [6:0][7:0] pins;
    int port;
    pins = {async_gen.io_port_g, async_gen.io_port_f, async_gen.io_port_e, async_gen.io_port_d,
            async_gen.io_port_c, async_gen.io_port_b, async_gen.io_port_a};
    port = (ch / 2) * 2 + c[3];
    if (c[7:4] == 4'h4 && ch < 8 && !(ch >= 6 && c[3])) return {1'b1, pins[port][c[2:0]] & pin_enable[port][c[2:0]]};
    if (c >= 8'hB0 && c <= 8'hB3) return {1'b1, async_gen.dead_time_timer[3 - c[1:0]]};
    return 2'b00;
  endfunction : ref_async
  function automatic logic ref_sync(logic [7:0] c);
    ecg_type_a_t ta;
    ta = c[3] ? sync_gen.type_a_timer_one : sync_gen.type_a_timer_zero;
    if (c >= 8'h60 && c <= 8'h65) return sync_gen.serial_host_clock[c[2:0]];
    if (c == 8'h68 || c == 8'h69) return sync_gen.spi_host_clock[c[0]];
    if (c[7:4] == 4'h8 && c[2:0] != 3'h2 && c[2:0] != 3'h3 && c[2:0] != 3'h7) return ta[c[2] ? 6 - c[2:0] : 4 - c[2:0]];
    if (c >= 8'hA0 && c <= 8'hA9) return sync_gen.type_b_timer[c[3:1]][!c[0]];
    return 1'b0;
  endfunction : ref_sync
  always @(posedge clock) begin
    for (int ch = 0; ch < N; ch++) exp_q[ch] <= reset_n ? ref_sync(channel_select[ch]) : 1'b0;
  end
  task automatic cmp(string what, int ch, logic got, logic exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: %s ch %0d got %b exp %b", $time, what, ch, got, exp);
    end
  endtask : cmp
  task automatic cmp_flag(int ch, logic got, logic exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: async flag ch %0d got %b exp %b", $time, ch, got, exp);
    end
  endtask : cmp_flag
  task automatic tick();
    logic [1:0] a;
    @(negedge clock);
    for (int ch = 0; ch < N; ch++) begin
      a = ref_async(ch, channel_select[ch]);
      cmp("event", ch, event_channel[ch], a[1] ? a[0] : exp_q[ch]);
      cmp_flag(ch, channel_is_async[ch], a[1]);
    end
    seed = xorshift(seed);
    rnd_a <= seed;
    seed = xorshift(seed);
    rnd_b <= seed;
    seed = xorshift(seed);
    rnd_c <= seed;
  endtask : tick
  task automatic random_codes(int cycles);
    repeat (cycles) begin
      tick();
      for (int ch = 0; ch < N; ch++) begin
        seed = xorshift(seed);
        if (seed[1:0] == 2'b00) channel_select[ch] = {hi_tbl[seed[10:8] % 6], seed[15:12]};
      end
    end
  endtask : random_codes
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial begin
    #60000;
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (8) tick();
    reset_n = 1'b1;
    for (int c = 0; c < 256; c++) begin
      tick();
      channel_select = {N{c[7:0]}};
      repeat (2) tick();
    end
    random_codes(2000);
    reset_n = 1'b0;
    repeat (3) tick();
    reset_n = 1'b1;
    random_codes(500);
    end_of_test();
  end
endmodule : ecg_event_channel_generator_mux_tb
